// [ppp_chk_properties.sv]
`timescale 1ns/10ps
module ppp_chk (
  // watched pins
  input wire sys_clk,
  input wire rst_b,
  input wire reset_pin_n_q,
  input wire chip_enable_n_q,
  input wire output_enable_n_q,
  input wire program_strobe_n_q,
  input wire byte_bus_oe_q,
  input wire [14:0] addr_q,
  input wire [3:0] tries_q,
  input wire fail_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_HOLD_RST: assert property (!reset_pin_n_q) else $error("device reset released");
  AST_NO_FIGHT: assert property (!chip_enable_n_q && !output_enable_n_q && program_strobe_n_q
    |-> !byte_bus_oe_q) else $error("bus driven while device outputs");
  AST_BYTE_PULSE: assert property (!program_strobe_n_q && !chip_enable_n_q
    |-> output_enable_n_q && byte_bus_oe_q) else $error("bad byte pulse");
  AST_PAGE_PULSE: assert property (!program_strobe_n_q && chip_enable_n_q
    |-> output_enable_n_q && !byte_bus_oe_q) else $error("bad page pulse");
  AST_RANGE: assert property (!program_strobe_n_q |-> addr_q <= 15'h5FFF)
    else $error("write above top");
  AST_TRIES: assert property (tries_q <= 4'hA) else $error("too many tries");
  AST_FAIL: assert property ($rose(fail_q) |-> tries_q == 4'hA)
    else $error("early fail");
endmodule // ppp_chk
bind ppp_programmer ppp_chk chk_u (.*);

// [ppp_consts.vh]
// Operation
// RULE_01 - write only 0000H..5FFFH, last address 5FFFH
// RULE_02 - programming mode: supply level, reset held low
// RULE_03 - page latch: four address/data bytes
// RULE_04 - page write: 0.1 ms low pulse
// RULE_05 - byte write pulse, then verify
// RULE_06 - retry write and verify up to ten
// RULE_07 - verify mode drives stored byte
// RULE_08 - read mode drives addressed byte
// RULE_09 - output enable high floats data
// RULE_10 - chip enable high means standby
// RULE_11 - program strobe high inhibits write
// RULE_12 - read: reset low, address, sample data
// RULE_13 - erased bytes read as FFH
// RULE_14 - report failure after maximum attempts
`ifndef PPP_CONSTS_VH
`define PPP_CONSTS_VH
`define PPP_ADDR_LAST 15'h5FFF
`define PPP_PAGE_BYTES 3'h4
`define PPP_MAX_TRIES 4'hA
`define PPP_ERASED 8'hFF
// 0.1 ms program pulse counted in 4 ns cycles
`define PPP_PULSE_CYC 16'h61A8
`define PPP_SETUP_CYC 8'h04
`define PPP_OP_READ 2'h0
`define PPP_OP_BYTE 2'h1
`define PPP_OP_PAGE 2'h2
`endif

// [ppp_programmer.v]
`timescale 1ns/10ps
`include "ppp_consts.vh"
module ppp_programmer #(
  parameter [15:0] PULSE_CYC = `PPP_PULSE_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // user command
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [14:0] cmd_addr,
  input wire [31:0] cmd_data,
  output reg cmd_ready_q,
  output reg done_q,
  output reg fail_q,
  output reg range_err_q,
  output reg [7:0] rd_data_q,
  output reg [3:0] tries_q,
  // device pins
  output reg reset_pin_n_q,
  output reg vpp_high_q,
  output reg chip_enable_n_q,
  output reg output_enable_n_q,
  output reg program_strobe_n_q,
  output reg [14:0] addr_q,
  output reg [7:0] byte_bus_o_q,
  output reg byte_bus_oe_q,
  input wire [7:0] byte_bus_i
);
  localparam S_IDLE = 3'h0;
  localparam S_LATCH = 3'h1;
  localparam S_PULSE = 3'h2;
  localparam S_VERIFY = 3'h3;
  localparam S_READ = 3'h4;
  localparam S_END = 3'h5;
  reg [2:0] st_q;
  reg [1:0] op_q;
  reg [31:0] data_q;
  reg [14:0] base_q;
  reg [1:0] idx_q;
  reg [15:0] cnt_q;
  reg [1:0] ph_q;
  function [7:0] pick;
    input [31:0] d;
    input [1:0] i;
    begin
      pick = d[i*8 +: 8];
    end
  endfunction
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      st_q <= S_IDLE;
      op_q <= 2'h0;
      data_q <= 32'h0;
      base_q <= 15'h0;
      idx_q <= 2'h0;
      cnt_q <= 16'h0;
      ph_q <= 2'h0;
      cmd_ready_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      range_err_q <= 1'b0;
      rd_data_q <= `PPP_ERASED;
      tries_q <= 4'h0;
      reset_pin_n_q <= 1'b0;
      vpp_high_q <= 1'b0;
      chip_enable_n_q <= 1'b1;
      output_enable_n_q <= 1'b1;
      program_strobe_n_q <= 1'b1;
      addr_q <= 15'h0;
      byte_bus_o_q <= 8'h0;
      byte_bus_oe_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      // RULE_02 reset held low
      reset_pin_n_q <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          cmd_ready_q <= 1'b1;
          // RULE_10 idle in standby
          chip_enable_n_q <= 1'b1;
          output_enable_n_q <= 1'b1;
          program_strobe_n_q <= 1'b1;
          byte_bus_oe_q <= 1'b0;
          if (cmd_valid && cmd_ready_q)
          begin
            cmd_ready_q <= 1'b0;
            op_q <= cmd_op;
            data_q <= cmd_data;
            base_q <= cmd_addr;
            idx_q <= 2'h0;
            cnt_q <= 16'h0;
            ph_q <= 2'h0;
            tries_q <= 4'h0;
            fail_q <= 1'b0;
            range_err_q <= 1'b0;
            addr_q <= cmd_addr;
            if (cmd_op == `PPP_OP_READ)
            begin
              // RULE_12 read-level supply
              vpp_high_q <= 1'b0;
              st_q <= S_READ;
            end
            // RULE_01 range guard
            else if (cmd_addr > `PPP_ADDR_LAST
                     || (cmd_op == `PPP_OP_PAGE
                         && (cmd_addr[1:0] != 2'h0
                             || cmd_addr > `PPP_ADDR_LAST - 15'h3)))
            begin
              range_err_q <= 1'b1;
              done_q <= 1'b1;
              st_q <= S_END;
            end
            else
            begin
              vpp_high_q <= 1'b1;
              st_q <= (cmd_op == `PPP_OP_PAGE) ? S_LATCH : S_PULSE;
            end
          end
        end
        S_LATCH:
        begin
          // address and data settle a cycle before output enable falls
          // RULE_03 latch four bytes
          chip_enable_n_q <= 1'b1;
          program_strobe_n_q <= 1'b1;
          addr_q <= base_q + {13'h0, idx_q};
          byte_bus_o_q <= pick(data_q, idx_q);
          byte_bus_oe_q <= 1'b1;
          cnt_q <= cnt_q + 16'h1;
          output_enable_n_q <= !(cnt_q[7:0] == 8'h1 || cnt_q[7:0] == 8'h2);
          if (cnt_q[7:0] == `PPP_SETUP_CYC)
          begin
            cnt_q <= 16'h0;
            output_enable_n_q <= 1'b1;
            idx_q <= idx_q + 2'h1;
            if (idx_q == 2'h3)
              st_q <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          // RULE_04 RULE_05 timed pulse
          tries_q <= (cnt_q == 16'h0) ? tries_q + 4'h1 : tries_q;
          output_enable_n_q <= 1'b1;
          chip_enable_n_q <= (op_q == `PPP_OP_PAGE);
          addr_q <= base_q;
          byte_bus_o_q <= pick(data_q, 2'h0);
          byte_bus_oe_q <= (op_q != `PPP_OP_PAGE);
          program_strobe_n_q <= 1'b0;
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q == PULSE_CYC)
          begin
            program_strobe_n_q <= 1'b1;
            cnt_q <= 16'h0;
            idx_q <= 2'h0;
            st_q <= S_VERIFY;
          end
        end
        S_VERIFY:
        begin
          // RULE_07 verify each byte
          byte_bus_oe_q <= 1'b0;
          chip_enable_n_q <= 1'b0;
          output_enable_n_q <= 1'b0;
          addr_q <= base_q + {13'h0, idx_q};
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q[7:0] == `PPP_SETUP_CYC)
          begin
            cnt_q <= 16'h0;
            rd_data_q <= byte_bus_i;
            output_enable_n_q <= 1'b1;
            if (byte_bus_i != pick(data_q, idx_q))
            begin
              // RULE_06 RULE_14 retry or fail
              if (tries_q == `PPP_MAX_TRIES)
              begin
                fail_q <= 1'b1;
                done_q <= 1'b1;
                st_q <= S_END;
              end
              else
                st_q <= (op_q == `PPP_OP_PAGE) ? S_LATCH : S_PULSE;
              idx_q <= 2'h0;
            end
            else if (op_q != `PPP_OP_PAGE || idx_q == 2'h3)
            begin
              done_q <= 1'b1;
              st_q <= S_END;
            end
            else
              idx_q <= idx_q + 2'h1;
          end
        end
        S_READ:
        begin
          // RULE_08 RULE_12 sample data
          chip_enable_n_q <= 1'b0;
          output_enable_n_q <= 1'b0;
          program_strobe_n_q <= 1'b1;
          byte_bus_oe_q <= 1'b0;
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q[7:0] == `PPP_SETUP_CYC)
          begin
            rd_data_q <= byte_bus_i;
            done_q <= 1'b1;
            st_q <= S_END;
          end
        end
        S_END:
        begin
          // RULE_09 release bus, outputs off
          chip_enable_n_q <= 1'b1;
          output_enable_n_q <= 1'b1;
          byte_bus_oe_q <= 1'b0;
          st_q <= S_IDLE;
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
endmodule // ppp_programmer

// [ppp_programmer_tb_top.sv]
`timescale 1ns/10ps
module ppp_programmer_tb_top;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg cmd_valid = 1'b0;
  reg [1:0] cmd_op = 2'h0;
  reg [14:0] cmd_addr = 15'h0000;
  reg [31:0] cmd_data = 32'h00000000;
  reg [7:0] flt = 8'h0F;
  wire cmd_ready_q, done_q, fail_q, range_err_q, reset_pin_n_q, vpp_high_q, d_oe;
  wire chip_enable_n_q, output_enable_n_q, program_strobe_n_q, byte_bus_oe_q;
  wire [7:0] rd_data_q, byte_bus_o_q, d_out, byte_bus_i;
  wire [3:0] tries_q;
  wire [14:0] addr_q;
  integer err_total = 0;
  integer num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  // undriven bus keeps changing so a stale value never matches
  always @(posedge sys_clk) flt <= ~flt;
  assign byte_bus_i = byte_bus_oe_q ? byte_bus_o_q : d_oe ? d_out : flt;
  ppp_programmer #(.PULSE_CYC(16'h0014)) dut_u (.*);
  ppp_prom_model #(.PULSE_NS(80)) dev_u (.rst_n(reset_pin_n_q), .vpp_hi(vpp_high_q),
    .ce_n(chip_enable_n_q), .oe_n(output_enable_n_q), .prog_n(program_strobe_n_q),
    .a(addr_q), .d_in(byte_bus_i), .d_out(d_out), .d_oe(d_oe));
  task end_of_test;
  begin
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input ok, input [63:0] msg);
  begin
    num_checks = num_checks + 1;
    if (ok !== 1'b1)
    begin
      err_total = err_total + 1;
      $display("MISMATCH %0t %s", $time, msg);
    end
  end
  endtask
  task run(input [1:0] op, input [14:0] a, input [31:0] d);
    integer n;
  begin
    for (n = 0; n < 100 && cmd_ready_q !== 1'b1; n = n + 1) @(posedge sys_clk);
    if (cmd_ready_q !== 1'b1)
    begin
      chk(1'b0, "no ready");
      end_of_test;
    end
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 3000 && done_q !== 1'b1; n = n + 1) @(posedge sys_clk);
    if (n == 3000)
    begin
      chk(1'b0, "timeout");
      end_of_test;
    end
  end
  endtask
  task sc_erased;
  begin
    run(2'h0, 15'h0010, 32'h0);
    chk(rd_data_q === 8'hFF, "erased");
  end
  endtask
  task sc_byte;
  begin
    run(2'h1, 15'h5FFF, 32'h3C);
    chk(tries_q === 4'h1 && fail_q === 1'b0, "byte");
    run(2'h0, 15'h5FFF, 32'h0);
    chk(rd_data_q === 8'h3C, "byte rd");
  end
  endtask
  task sc_page;
  begin
    run(2'h2, 15'h0100, 32'h44332211);
    run(2'h0, 15'h0102, 32'h0);
    chk(rd_data_q === 8'h33, "page rd");
  end
  endtask
  task sc_range;
  begin
    run(2'h1, 15'h6000, 32'h55);
    chk(range_err_q === 1'b1, "range");
    run(2'h2, 15'h0101, 32'h0);
    chk(range_err_q === 1'b1, "align");
  end
  endtask
  task sc_stuck;
  begin
    run(2'h1, 15'h0123, 32'h00);
    chk(fail_q === 1'b1 && tries_q === 4'hA, "retries");
    run(2'h2, 15'h0120, 32'h00000000);
    chk(fail_q === 1'b1 && tries_q === 4'hA, "pg stuck");
    run(2'h0, 15'h0121, 32'h0);
    chk(rd_data_q === 8'h00, "pg kept");
  end
  endtask
  task sc_retry;
  begin
    run(2'h1, 15'h0200, 32'h5A);
    chk(tries_q === 4'h2 && fail_q === 1'b0 && rd_data_q === 8'h5A, "retry");
  end
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    sc_erased;
    sc_byte;
    sc_page;
    sc_range;
    sc_stuck;
    sc_retry;
    end_of_test;
  end
endmodule // ppp_programmer_tb_top

// [ppp_prom_model.sv]
`timescale 1ns/10ps
module ppp_prom_model #(
  parameter PULSE_NS = 80,
  parameter [14:0] STUCK = 15'h0123,
  parameter [14:0] WEAK = 15'h0200
) (
  // device pins
  input wire rst_n,
  input wire vpp_hi,
  input wire ce_n,
  input wire oe_n,
  input wire prog_n,
  input wire [14:0] a,
  input wire [7:0] d_in,
  output wire [7:0] d_out,
  output wire d_oe
);
  reg [7:0] m [0:32767];
  reg [7:0] lat [0:3];
  reg [7:0] dd;
  reg [14:0] aa;
  reg [14:0] base;
  realtime t0;
  integer i;
  // weak cell needs a second byte pulse (page writes take it on the first), stuck cell never takes one
  reg weak_left = 1'b1;
  initial for (i = 0; i < 32768; i = i + 1) m[i] = 8'hFF;
  assign d_oe = !rst_n && !ce_n && !oe_n && prog_n;
  assign d_out = m[a];
  // page latch, level capture avoids edge races
  always @*
    if (!oe_n && ce_n && prog_n)
    begin
      lat[a[1:0]] = d_in;
      base = a & 15'h7FFC;
    end
  always @*
    if (!prog_n && !ce_n)
    begin
      dd = d_in;
      aa = a;
    end
  always @(negedge prog_n) t0 = $realtime;
  always @(posedge prog_n)
    if (!rst_n && vpp_hi && oe_n && $realtime - t0 >= PULSE_NS)
    begin
      if (!ce_n && aa == WEAK && weak_left)
        weak_left = 1'b0;
      else if (!ce_n && aa != STUCK)
        m[aa] = dd;
      if (ce_n)
        for (i = 0; i < 4; i = i + 1)
          if (base + i != STUCK)
            m[base + i] = lat[i];
    end
endmodule // ppp_prom_model
